// ### pkg/dtsf_map.vh
`ifndef DTSF_MAP_VH
`define DTSF_MAP_VH
// Byte time 960 ns; index mark two bytes, sector mark one byte
`define DTSF_CLK_NS 20
`define DTSF_BYTE_NS 960
`define DTSF_BYTE_CYC (`DTSF_BYTE_NS / `DTSF_CLK_NS)
`define DTSF_IDX_NS 1920
`define DTSF_IDX_BYTES 2'h2
`define DTSF_SEC_NS 960
`define DTSF_SEC_BYTES 1
// Track length in bytes per revolution (plain default)
`define DTSF_TRACK_BYTES 16'h5000
// Overhead bytes per sector: mark, gaps, address field, data sync, CRC, fill
`define DTSF_SEC_OVH 16'h003D
// Space ahead of first sector: index, gap1, skip record
`define DTSF_HDR_BYTES 16'h0027
`define DTSF_SIZE_W 3
`define DTSF_SIZE_RST 3'h2
`define DTSF_CYL_ZERO 10'h000
// Sequence-up states
`define DTSF_ST_IDLE 3'h0
`define DTSF_ST_SPIN 3'h1
`define DTSF_ST_SIZE 3'h2
`define DTSF_ST_HOME 3'h3
`define DTSF_ST_RDY 3'h4
`endif

// ### core/dtsf_formatter.v
// Overview of operation
// - Track zero is outermost; track numbers rise toward the hub.
// - Index mark pulse of two byte times, once per revolution.
// - Sector-size switches are sampled only during sequence-up.
// - Sector mark pulse of one byte time at each sector start.
// - Byte counter restarts on each index pulse.
// - Spin up, then read size, home heads, then set ready and clear busy on the same clock.
`timescale 1ns/1ns
`include "dtsf_map.vh"
`default_nettype none
module dtsf_formatter (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Servo and drive status pins
  input wire servo_index_in,
  input wire spindle_at_speed_in,
  input wire heads_at_zero_in,
  input wire [`DTSF_SIZE_W-1:0] size_switch_in,
  // Commands from controller
  input wire seq_up_in,
  input wire seq_down_in,
  // Marks and status
  output reg index_mark_r,
  output reg sector_mark_r,
  output reg ready_r,
  output reg busy_r,
  output reg spindle_on_r,
  output reg home_req_r,
  output reg [`DTSF_SIZE_W-1:0] sector_size_r,
  output reg [7:0] sector_num_r,
  output reg [9:0] cylinder_r
);
  // Sector span bytes: 128 shifted by switch code, plus overhead
  function [15:0] sec_span;
    input [`DTSF_SIZE_W-1:0] code;
    begin
      sec_span = (16'h0080 << code) + `DTSF_SEC_OVH;
    end
  endfunction

  // Two-flop synchronisers, one per pin
  reg [1:0] idx_s;
  reg [1:0] spd_s;
  reg [1:0] hz_s;
  reg [1:0] up_s;
  reg [1:0] dn_s;
  reg [`DTSF_SIZE_W-1:0] sw_s1;
  reg [`DTSF_SIZE_W-1:0] sw_s2;
  reg idx_d;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      idx_s <= 2'h0;
      idx_d <= 1'b0;
    end else begin
      idx_s <= {idx_s[0], servo_index_in};
      idx_d <= idx_s[1];
    end
  end
  // Index pin idles low, so reset leaves no false edge
  wire idx_rise = idx_s[1] & ~idx_d;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      spd_s <= 2'h0;
    end else begin
      spd_s <= {spd_s[0], spindle_at_speed_in};
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hz_s <= 2'h0;
    end else begin
      hz_s <= {hz_s[0], heads_at_zero_in};
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      up_s <= 2'h0;
    end else begin
      up_s <= {up_s[0], seq_up_in};
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dn_s <= 2'h0;
    end else begin
      dn_s <= {dn_s[0], seq_down_in};
    end
  end

  // Switches are static in use; no gray code needed
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sw_s1 <= 3'h0;
      sw_s2 <= 3'h0;
    end else begin
      sw_s1 <= size_switch_in;
      sw_s2 <= sw_s1;
    end
  end

  // Sequence-up controller
  reg [2:0] st_r, st_nxt;
  always @* begin
    st_nxt = st_r;
    case (st_r)
      `DTSF_ST_IDLE: if (up_s[1]) st_nxt = `DTSF_ST_SPIN;
      `DTSF_ST_SPIN: if (spd_s[1]) st_nxt = `DTSF_ST_SIZE;
      `DTSF_ST_SIZE: st_nxt = `DTSF_ST_HOME;
      `DTSF_ST_HOME: if (hz_s[1]) st_nxt = `DTSF_ST_RDY;
      `DTSF_ST_RDY: st_nxt = `DTSF_ST_RDY;
      default: st_nxt = `DTSF_ST_IDLE;
    endcase
    if (dn_s[1]) st_nxt = `DTSF_ST_IDLE;
  end
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= `DTSF_ST_IDLE;
      sector_size_r <= `DTSF_SIZE_RST;
      ready_r <= 1'b0;
      busy_r <= 1'b0;
      spindle_on_r <= 1'b0;
      home_req_r <= 1'b0;
      cylinder_r <= `DTSF_CYL_ZERO;
    end else begin
      st_r <= st_nxt;
      // Switch changes ignored outside this one state
      if (st_r == `DTSF_ST_SIZE)
        sector_size_r <= sw_s2;
      spindle_on_r <= (st_nxt != `DTSF_ST_IDLE);
      home_req_r <= (st_nxt == `DTSF_ST_HOME);
      if (st_r == `DTSF_ST_HOME && hz_s[1])
        cylinder_r <= `DTSF_CYL_ZERO;
      ready_r <= (st_nxt == `DTSF_ST_RDY);
      busy_r <= (st_nxt != `DTSF_ST_IDLE) && (st_nxt != `DTSF_ST_RDY);
    end
  end

  // Byte clock and byte counter restarted by index
  reg [5:0] cyc_r;
  reg [15:0] byte_r;
  reg [15:0] sec_left_r;
  reg in_sectors_r;
  reg [1:0] idx_left_r;
  wire byte_tick = (cyc_r == `DTSF_BYTE_CYC - 1);
  wire [15:0] span = sec_span(sector_size_r);
  // Only whole sectors get marks; the tail is gap three
  wire room = (byte_r + span) <= `DTSF_TRACK_BYTES;
  // A mark never starts in the cycle that ready drops
  wire mark_ok = ready_r & ~dn_s[1];

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cyc_r <= 6'h00;
      byte_r <= 16'h0000;
    end else if (idx_rise) begin
      cyc_r <= 6'h00;
      byte_r <= 16'h0000;
    end else begin
      cyc_r <= byte_tick ? 6'h00 : cyc_r + 6'h01;
      if (byte_tick)
        byte_r <= byte_r + 16'h0001;
    end
  end

  // Index mark lasts two byte times
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      idx_left_r <= 2'h0;
      index_mark_r <= 1'b0;
    end else if (idx_rise) begin
      idx_left_r <= `DTSF_IDX_BYTES - 2'h1;
      index_mark_r <= mark_ok;
    end else if (byte_tick) begin
      if (idx_left_r != 2'h0)
        idx_left_r <= idx_left_r - 2'h1;
      else
        index_mark_r <= 1'b0;
    end
  end

  // Sector marks counted from the index
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sec_left_r <= 16'h0000;
      in_sectors_r <= 1'b0;
      sector_mark_r <= 1'b0;
      sector_num_r <= 8'h00;
    end else if (idx_rise) begin
      sec_left_r <= `DTSF_HDR_BYTES;
      in_sectors_r <= 1'b0;
      sector_mark_r <= 1'b0;
      sector_num_r <= 8'h00;
    end else begin
      if (byte_tick) begin
        sector_mark_r <= 1'b0;
        if (sec_left_r > 16'h0001) begin
          sec_left_r <= sec_left_r - 16'h0001;
        end else if (sec_left_r == 16'h0001) begin
          if (room && mark_ok) begin
            sector_mark_r <= 1'b1;
            sec_left_r <= span;
            if (in_sectors_r)
              sector_num_r <= sector_num_r + 8'h01;
            in_sectors_r <= 1'b1;
          end else begin
            sec_left_r <= 16'h0000;
          end
        end
      end
    end
  end
endmodule
`default_nettype wire

// ### bench/dtsf_mech.sv
`timescale 1ns/1ns
`default_nettype none
module dtsf_mech #(
  // Controller-side field check codes
  parameter logic [15:0] CRC_POLY = 16'h1021,
  parameter logic [15:0] CRC_SEED = 16'hFFFF
) (
  // Clock
  input wire logic clk,
  // Drive commands
  input wire logic spin,
  input wire logic home,
  input wire logic fire,
  // Mechanics status
  output logic at_speed,
  output logic at_zero,
  output logic index
);
  int sp = 0;
  int hm = 0;
  int ix = 0;
  always @(posedge clk) begin
    sp <= spin ? sp + 1 : 0;
    hm <= home ? hm + 1 : 0;
    ix <= fire ? 300 : (ix > 0 ? ix - 1 : 0);
  end
  // Spin-up and seek are slow on purpose
  assign at_speed = sp > 40;
  assign at_zero = hm > 15;
  assign index = ix > 0;
endmodule
`default_nettype wire

// ### bench/dtsf_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module dtsf_checker (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic index_mark_r,
  input wire logic sector_mark_r,
  input wire logic ready_r,
  input wire logic busy_r,
  input wire logic [2:0] sector_size_r,
  input wire logic [9:0] cylinder_r
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [7:0] ic_r;
  logic [7:0] sc_r;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ic_r <= 8'h00;
      sc_r <= 8'h00;
    end else begin
      ic_r <= index_mark_r ? ic_r + 8'h01 : 8'h00;
      sc_r <= sector_mark_r ? sc_r + 8'h01 : 8'h00;
    end
  end
  idx_width_a: assert property ($fell(index_mark_r) |-> ic_r == 8'h60)
    else $error("index mark width wrong");
  sec_width_a: assert property ($fell(sector_mark_r) |-> sc_r == 8'h30)
    else $error("sector mark width wrong");
  mark_ready_a: assert property ($rose(sector_mark_r) |-> ready_r)
    else $error("sector mark while not ready");
  size_hold_a: assert property (ready_r && $past(ready_r) |-> $stable(sector_size_r))
    else $error("sector size moved while ready");
  ready_home_a: assert property ($rose(ready_r) |-> !busy_r && cylinder_r == 10'h000)
    else $error("ready before homing done");
  idx_sec_a: assert property ($rose(index_mark_r) |-> !sector_mark_r)
    else $error("sector mark at index restart");
endmodule
bind dtsf_formatter dtsf_checker i_chk (.clk(clk), .rst_n(rst_n),
  .index_mark_r(index_mark_r), .sector_mark_r(sector_mark_r), .ready_r(ready_r),
  .busy_r(busy_r), .sector_size_r(sector_size_r), .cylinder_r(cylinder_r));
`default_nettype wire

// ### bench/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic clk, rst_n, fire, seq_up, seq_down, pi, ps;
  logic [2:0] size_sw;
  wire at_speed, at_zero, index, im, sm, rdy, busy, spin, home;
  wire [2:0] ssz;
  wire [7:0] snum;
  wire [9:0] cyl;
  int n_mismatch = 0, checked = 0, cyc = 0, t_i = 0, t_f = 0;
  int t_s[$];
  typedef struct {logic [2:0] code; int span;} dtsf_row_t;
  dtsf_row_t rows[2] = '{'{3'h0, 9072}, '{3'h1, 15216}};
  dtsf_formatter i_dut (.clk(clk), .rst_n(rst_n), .servo_index_in(index),
    .spindle_at_speed_in(at_speed), .heads_at_zero_in(at_zero), .size_switch_in(size_sw),
    .seq_up_in(seq_up), .seq_down_in(seq_down), .index_mark_r(im), .sector_mark_r(sm),
    .ready_r(rdy), .busy_r(busy), .spindle_on_r(spin), .home_req_r(home),
    .sector_size_r(ssz), .sector_num_r(snum), .cylinder_r(cyl));
  dtsf_mech i_mech (.clk(clk), .spin(spin), .home(home), .fire(fire),
    .at_speed(at_speed), .at_zero(at_zero), .index(index));
  initial begin
    clk = 0;
    forever #10 clk = ~clk;
  end
  always @(negedge clk) begin
    cyc++;
    if (im === 1'b1 && pi !== 1'b1) begin
      t_i = cyc;
      t_s.delete();
    end
    if (im !== 1'b1 && pi === 1'b1) t_f = cyc;
    if (sm === 1'b1 && ps !== 1'b1) t_s.push_back(cyc);
    pi = im;
    ps = sm;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  task automatic final_report;
    $display("mismatches %0d checks %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic wait_ready;
    int j;
    for (j = 0; j < 1000 && rdy !== 1'b1; j++) @(negedge clk);
    if (j == 1000) begin
      n_mismatch++;
      final_report();
    end
  endtask
  initial begin
    rst_n = 0; fire = 0; seq_up = 0; seq_down = 0; size_sw = 3'h0;
    repeat (6) @(negedge clk);
    rst_n = 1;
    repeat (4) @(negedge clk);
    foreach (rows[k]) begin
      size_sw = rows[k].code;
      seq_down = 0;
      seq_up = 1;
      wait_ready();
      size_sw = 3'h5;
      repeat (4) @(negedge clk);
      chk(ssz, rows[k].code);
      fire = 1;
      @(negedge clk);
      fire = 0;
      repeat (1900 + 2 * rows[k].span) @(negedge clk);
      chk(t_f - t_i, 96);
      chk(t_s[0] - t_i, 1872);
      chk(t_s[1] - t_s[0], rows[k].span);
      chk((t_s[0] - t_i) / 48 >= 2 + 23 + 13, 1'b1);
      chk((t_s[1] - t_s[0]) / 48 - (128 << rows[k].code) >= 49, 1'b1);
      chk(snum, 8'h02);
      chk(busy, 1'b0);
      chk(cyl, 10'h000);
      seq_up = 0;
      seq_down = 1;
      repeat (10) @(negedge clk);
      chk(rdy, 1'b0);
    end
    rst_n = 0;
    @(negedge clk);
    chk(ssz, 3'h2);
    final_report();
  end
endmodule
`default_nettype wire
